// ===== design/lspc_pkg.sv
// package: register map, fields and constants of the link status and pin config block
// ==========================================================================
package lspc_pkg;
  // ========================================================================
  // register offsets
  localparam logic [7:0] ERR_CLEAR_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam logic [7:0] PIN0_ADDR = 8'h0D;
  localparam logic [7:0] PIN12_ADDR = 8'h0E;
  localparam logic [7:0] PORT_SEL_ADDR = 8'h1E;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h20;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h21;
  // ========================================================================
  // field positions
  localparam int ERR_CLEAR_BIT = 5;
  localparam int PORT_SEL_BIT = 0;
  localparam int ST_INPUT_ERR = 6;
  localparam int ST_LANE_ERR = 5;
  localparam int ST_LINK_LOST = 4;
  localparam int ST_SELFTEST = 3;
  localparam int ST_PCLK = 2;
  localparam int ST_FAR_CRC = 1;
  localparam int ST_LINK_DET = 0;
  localparam int LEVEL_LO = 3;
  localparam int LEVEL_HI = 7;
  localparam int MODE_HI_LSB = 4;
  // ========================================================================
  // reset values and identity
  localparam logic [3:0] CFG_RESET = 4'h0;
  // arbitrary neutral revision value
  localparam logic [3:0] REVISION_DEFAULT = 4'h5;
  // ========================================================================
  // pin modes
  typedef enum logic [2:0] {
    LSPC_MODE_OUT = 3'h1,
    LSPC_MODE_IN = 3'h3,
    LSPC_MODE_HOLD = 3'h5,
    LSPC_MODE_DEFAULT = 3'h7
  } lspc_mode_t;
  localparam logic [1:0] MODE_FUNC_LOW = 2'h0;
  localparam logic [1:0] MODE_TRI_LOW = 2'h2;
endpackage : lspc_pkg

// ===== design/lspc_link_status_pin_config.sv
// module: link status register and three-pin config with port steering
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lspc_link_status_pin_config #(
  parameter logic [3:0] SILICON_REVISION = lspc_pkg::REVISION_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // display input error sources, one set per input
  input wire logic [4:0] inputErrA,
  input wire logic [4:0] inputErrB,
  input wire logic [1:0] laneErrA,
  input wire logic [1:0] laneErrB,
  input wire logic dualInputMode,
  // per serial port status, index 1 is the second port
  input wire logic [1:0] linkLostEvent,
  input wire logic [1:0] selftestCrcEvent,
  input wire logic [1:0] selftestRestart,
  input wire logic [1:0] farCrcEvent,
  input wire logic [1:0] pixelClockValid,
  input wire logic [1:0] cableDetect,
  input wire logic [1:0] linkUp,
  // remote pin data per port, bits are pins 0 to 2
  input wire logic [2:0] remoteData0,
  input wire logic [2:0] remoteData1,
  // pins: port 0 on bits 2:0, port 1 on bits 5:3
  input wire logic [5:0] pinIn,
  output logic [5:0] pinOut,
  output logic [5:0] pinOe,
  // pin inputs and functional inputs to the core
  output logic [5:0] pinInputValue,
  output logic [5:0] functionalInput,
  // interrupt
  output logic irq
);
  // ==========================================================================
  // config storage, both ports
  logic portSel;
  logic [7:0] pin0Cfg [2];
  logic [7:0] pin12Cfg [2];
  logic [6:0] linkLost;
  logic [1:0] linkLostFlag;
  logic [1:0] selftestFlag;
  logic [1:0] farCrcFlag;
  logic [6:0] irqStatus;
  logic [6:0] irqMask;
  logic [6:0] statusView;
  logic errClear;
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [5:0] syncC;
  logic [5:0] pinStable;
  logic [5:0] holdLevel;
  logic [6:0] events;

  // ==========================================================================
  // write decode, shared by the clear, port select and interrupt register targets
  function automatic logic writeHit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] target);
    logic hit;
    hit = strobe && (addr == target);
    return hit;
  endfunction : writeHit

  // clear is a strobe only, nothing stored
  assign errClear = writeHit(regWrite, regAddr, lspc_pkg::ERR_CLEAR_ADDR)
    && regWriteData[lspc_pkg::ERR_CLEAR_BIT];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      portSel <= 1'b0;
    end else if (writeHit(regWrite, regAddr, lspc_pkg::PORT_SEL_ADDR)) begin
      portSel <= regWriteData[lspc_pkg::PORT_SEL_BIT];
    end
  end

  // writes go to the selected port copy
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin0Cfg[0] <= 8'h00;
      pin0Cfg[1] <= 8'h00;
      pin12Cfg[0] <= 8'h00;
      pin12Cfg[1] <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == lspc_pkg::PIN0_ADDR) begin
        pin0Cfg[portSel] <= {lspc_pkg::CFG_RESET, regWriteData[3:0]};
      end
      if (regAddr == lspc_pkg::PIN12_ADDR) begin
        pin12Cfg[portSel] <= regWriteData;
      end
    end
  end

  // ==========================================================================
  // sticky link flags, set wins over clear
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : gFlags
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          linkLostFlag[p] <= 1'b0;
        end else if (linkLostEvent[p]) begin
          linkLostFlag[p] <= 1'b1;
        end else if (errClear) begin
          linkLostFlag[p] <= 1'b0;
        end
      end
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          selftestFlag[p] <= 1'b0;
        end else if (selftestCrcEvent[p]) begin
          selftestFlag[p] <= 1'b1;
        end else if (errClear || selftestRestart[p]) begin
          selftestFlag[p] <= 1'b0;
        end
      end
      // far-end CRC flag cleared by loss or clear
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          farCrcFlag[p] <= 1'b0;
        end else if (farCrcEvent[p]) begin
          farCrcFlag[p] <= 1'b1;
        end else if (errClear || linkLostEvent[p]) begin
          farCrcFlag[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // status view
  always_comb begin
    statusView = 7'h00;
    // input error OR, not cleared by read
    statusView[lspc_pkg::ST_INPUT_ERR] = (|inputErrA) || (dualInputMode && (|inputErrB));
    // lane error OR of input A, and of input B in dual input mode
    statusView[lspc_pkg::ST_LANE_ERR] = (|laneErrA) || (dualInputMode && (|laneErrB));
    statusView[lspc_pkg::ST_LINK_LOST] = linkLostFlag[portSel];
    statusView[lspc_pkg::ST_SELFTEST] = selftestFlag[portSel];
    // pixel clock valid of selected port
    statusView[lspc_pkg::ST_PCLK] = pixelClockValid[portSel];
    statusView[lspc_pkg::ST_FAR_CRC] = farCrcFlag[portSel];
    statusView[lspc_pkg::ST_LINK_DET] = cableDetect[portSel];
  end
  assign linkLost = statusView;

  // ==========================================================================
  // interrupts: events from rising status, write one to clear
  logic [6:0] statusPrev;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      statusPrev <= 7'h00;
    end else begin
      statusPrev <= linkLost;
    end
  end
  assign events = linkLost & ~statusPrev;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= 7'h00;
    end else if (writeHit(regWrite, regAddr, lspc_pkg::IRQ_STATUS_ADDR)) begin
      irqStatus <= (irqStatus & ~regWriteData[6:0]) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqMask <= 7'h00;
    end else if (writeHit(regWrite, regAddr, lspc_pkg::IRQ_MASK_ADDR)) begin
      irqMask <= regWriteData[6:0];
    end
  end
  assign irq = |(irqStatus & irqMask);

  // ==========================================================================
  // register read, data the cycle after the strobe
  logic [7:0] next_readData;
  always_comb begin
    next_readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        lspc_pkg::STATUS_ADDR: next_readData = {1'b0, linkLost};
        lspc_pkg::PIN0_ADDR: next_readData = {SILICON_REVISION, pin0Cfg[portSel][3:0]};
        lspc_pkg::PIN12_ADDR: next_readData = pin12Cfg[portSel];
        lspc_pkg::PORT_SEL_ADDR: next_readData = {7'h00, portSel};
        lspc_pkg::IRQ_STATUS_ADDR: next_readData = {1'b0, irqStatus};
        lspc_pkg::IRQ_MASK_ADDR: next_readData = {1'b0, irqMask};
        default: next_readData = 8'h00;
      endcase
    end
  end

  // zero outside the answer cycle, so a stale value never looks like data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

  // ==========================================================================
  // pin input synchronisers: change counts when stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 6'h00;
      syncB <= 6'h00;
      syncC <= 6'h00;
      pinStable <= 6'h00;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
      // per pin, so a bouncing neighbour never delays a settled pin
      for (int b = 0; b < 6; b++) begin
        if (syncB[b] == syncC[b]) begin
          pinStable[b] <= syncC[b];
        end
      end
    end
  end

  // ==========================================================================
  // pin drivers
  function automatic logic [2:0] pinMode(input logic [7:0] p0, input logic [7:0] p12,
                                         input int idx);
    logic [2:0] m;
    m = 3'h0;
    case (idx)
      0: m = p0[2:0];
      1: m = p12[2:0];
      default: m = p12[lspc_pkg::MODE_HI_LSB +: 3];
    endcase
    return m;
  endfunction : pinMode

  function automatic logic pinLevel(input logic [7:0] p0, input logic [7:0] p12,
                                    input int idx);
    logic l;
    l = 1'b0;
    case (idx)
      0: l = p0[lspc_pkg::LEVEL_LO];
      1: l = p12[lspc_pkg::LEVEL_LO];
      default: l = p12[lspc_pkg::LEVEL_HI];
    endcase
    return l;
  endfunction : pinLevel

  genvar q;
  generate
    for (q = 0; q < 6; q++) begin : gPins
      localparam int PORT = q / 3;
      localparam int IDX = q % 3;
      logic [2:0] mode;
      logic level;
      logic remote;
      logic next_out;
      logic next_oe;
      assign mode = pinMode(pin0Cfg[PORT], pin12Cfg[PORT], IDX);
      assign level = pinLevel(pin0Cfg[PORT], pin12Cfg[PORT], IDX);
      assign remote = (PORT == 0) ? remoteData0[IDX] : remoteData1[IDX];

      // hold the last remote level while link is down
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          holdLevel[q] <= 1'b0;
        end else if (linkUp[PORT]) begin
          holdLevel[q] <= remote;
        end
      end

      always_comb begin
        next_out = 1'b0;
        next_oe = 1'b0;
        case (mode)
          // local level in local output mode; default mode also uses it while link is down
          lspc_pkg::LSPC_MODE_OUT: begin
            next_out = level;
            next_oe = 1'b1;
          end
          lspc_pkg::LSPC_MODE_HOLD: begin
            next_out = linkUp[PORT] ? remote : holdLevel[q];
            next_oe = 1'b1;
          end
          lspc_pkg::LSPC_MODE_DEFAULT: begin
            next_out = linkUp[PORT] ? remote : level;
            next_oe = 1'b1;
          end
          // functional input, tri-state, general input undriven
          default: begin
            next_out = 1'b0;
            next_oe = 1'b0;
          end
        endcase
      end

      // registered pin drive, no glitch while a mode write lands
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pinOut[q] <= 1'b0;
          pinOe[q] <= 1'b0;
        end else begin
          pinOut[q] <= next_out;
          pinOe[q] <= next_oe;
        end
      end

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          functionalInput[q] <= 1'b0;
          pinInputValue[q] <= 1'b0;
        end else begin
          functionalInput[q] <= (mode[1:0] == lspc_pkg::MODE_FUNC_LOW) ? pinStable[q] : 1'b0;
          pinInputValue[q] <= (mode == lspc_pkg::LSPC_MODE_IN) ? pinStable[q] : 1'b0;
        end
      end
    end
  endgenerate
endmodule : lspc_link_status_pin_config
`default_nettype wire

// ===== test/lspc_pin_model.sv
// partner: external pin circuitry seen by the pins
`timescale 1ns/1ps
`default_nettype none
module lspc_pin_model (
  // design side
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  output logic [5:0] pinIn,
  // external drivers
  input wire logic [5:0] extOe,
  input wire logic [5:0] extLevel
);
  // ==========
  // wire level
  // weak pull-down so a released pin never shows a stale level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : (extOe[i] & extLevel[i]);
    end
  end
endmodule : lspc_pin_model
`default_nettype wire

// ===== test/lspc_link_status_pin_config_chk.sv
// checker: port assertions for the status and pin block
`timescale 1ns/1ps
`default_nettype none
module lspc_chk #(
  parameter logic [3:0] SILICON_REVISION = 4'h0
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  // status sources and outputs
  input wire logic [4:0] inputErrA,
  input wire logic [1:0] laneErrA,
  input wire logic [1:0] pixelClockValid,
  input wire logic [1:0] cableDetect,
  input wire logic [5:0] pinOe,
  input wire logic irq
);
  // ==========
  // properties
  logic stRd;
  assign stRd = regRead && regAddr == lspc_pkg::STATUS_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_rev_fixed: assert property (regRead && regAddr == 8'h0D |=> regReadData[7:4] == SILICON_REVISION)
    else $error("revision field wrong");
  chk_input_or: assert property (stRd && |inputErrA && $past(|inputErrA) |=> regReadData[6])
    else $error("input error summary missing");
  chk_lane_or: assert property (stRd && |laneErrA && $past(|laneErrA) |=> regReadData[5])
    else $error("lane error summary missing");
  chk_cable_seen: assert property (stRd && &cableDetect && $stable(cableDetect) |=> regReadData[0])
    else $error("cable detect missing");
  chk_cable_none: assert property (stRd && cableDetect == 2'h0 ##1 1'b1 |-> !regReadData[0])
    else $error("cable detect without cable");
  chk_pclk_seen: assert property (stRd && &pixelClockValid && $stable(pixelClockValid) |=> regReadData[2])
    else $error("pixel clock flag missing");
  chk_pclk_none: assert property (stRd && pixelClockValid == 2'h0 |=> !regReadData[2])
    else $error("pixel clock flag without clock");
  chk_status_rsvd: assert property (stRd |=> regReadData[7] == 1'b0)
    else $error("status bit 7 set");
  cover property (stRd ##1 regReadData[4]);
  cover property ($rose(irq));
  cover property (|pinOe);
endmodule : lspc_chk
bind lspc_link_status_pin_config lspc_chk #(.SILICON_REVISION(SILICON_REVISION)) chk_u (
  .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regRead(regRead),
  .regReadData(regReadData), .inputErrA(inputErrA), .laneErrA(laneErrA),
  .pixelClockValid(pixelClockValid), .cableDetect(cableDetect), .pinOe(pinOe), .irq(irq)
);
`default_nettype wire

// ===== test/testbench.sv
// testbench: register, status, pin and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ST = lspc_pkg::STATUS_ADDR;
  localparam logic [7:0] P0 = lspc_pkg::PIN0_ADDR;
  localparam logic [7:0] P12 = lspc_pkg::PIN12_ADDR;
  localparam logic [7:0] SEL = lspc_pkg::PORT_SEL_ADDR;
  localparam logic [7:0] IST = lspc_pkg::IRQ_STATUS_ADDR;
  // arbitrary revision value
  localparam logic [3:0] REV = 4'hA;
  logic clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, dualInputMode = 1'b0;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, regReadData;
  logic [4:0] inputErrA = 5'h00, inputErrB = 5'h00;
  logic [1:0] laneErrA = 2'h0, laneErrB = 2'h0, linkLostEvent = 2'h0, selftestCrcEvent = 2'h0;
  logic [1:0] selftestRestart = 2'h0, farCrcEvent = 2'h0, pixelClockValid = 2'h0;
  logic [1:0] cableDetect = 2'h0, linkUp = 2'h0;
  logic [2:0] remoteData0 = 3'h0, remoteData1 = 3'h0;
  logic [5:0] extOe = 6'h00, extLevel = 6'h00, pinIn, pinOut, pinOe, pinInputValue, functionalInput;
  logic irq;
  int checks = 0;
  int failCount = 0;
  always #4 clock = ~clock;
  lspc_link_status_pin_config #(.SILICON_REVISION(REV)) dut_u (
    .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .inputErrA(inputErrA), .inputErrB(inputErrB), .laneErrA(laneErrA), .laneErrB(laneErrB),
    .dualInputMode(dualInputMode), .linkLostEvent(linkLostEvent),
    .selftestCrcEvent(selftestCrcEvent), .selftestRestart(selftestRestart),
    .farCrcEvent(farCrcEvent), .pixelClockValid(pixelClockValid), .cableDetect(cableDetect),
    .linkUp(linkUp), .remoteData0(remoteData0), .remoteData1(remoteData1), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pinInputValue(pinInputValue),
    .functionalInput(functionalInput), .irq(irq)
  );
  lspc_pin_model pm_u (
    .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .extOe(extOe), .extLevel(extLevel)
  );
  // ==========
  // tasks
  task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : compare
  // idle cycle after so the strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    compare(regReadData, exp);
    @(posedge clock);
  endtask : rdchk
  task automatic pulse(input int k, input logic [1:0] p);
    case (k)
      0: linkLostEvent <= p;
      1: farCrcEvent <= p;
      2: selftestCrcEvent <= p;
      default: selftestRestart <= p;
    endcase
    @(posedge clock);
    {linkLostEvent, farCrcEvent, selftestCrcEvent, selftestRestart} <= 8'h00;
    repeat (2) @(posedge clock);
  endtask : pulse
  task automatic errClear;
    wr(lspc_pkg::ERR_CLEAR_ADDR, 8'h20);
    wr(lspc_pkg::ERR_CLEAR_ADDR, 8'h00);
  endtask : errClear
  // idx 0-5 pin {oe, out}, 6 pin 1 {functional, input}, 7 irq
  task automatic look(input int idx, input logic [1:0] exp);
    logic [1:0] v;
    repeat (6) @(posedge clock);
    @(negedge clock);
    if (idx == 7) v = {1'b0, irq};
    else if (idx == 6) v = {functionalInput[1], pinInputValue[1]};
    else v = {pinOe[idx], pinOut[idx] & pinOe[idx]};
    compare({6'h00, v}, {6'h00, exp});
    @(posedge clock);
  endtask : look
  task automatic testDone;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : testDone
  // ==========
  // scenarios
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rdchk(P0, {REV, 4'h0});
    wr(ST, 8'hFF);
    rdchk(ST, 8'h00);
    wr(P0, 8'hF4);
    rdchk(P0, {REV, 4'h4});
    rdchk(8'hFF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      inputErrA <= 5'h01 << i;
      @(posedge clock);
      rdchk(ST, 8'h40);
    end
    inputErrA <= 5'h00;
    inputErrB <= 5'h04;
    @(posedge clock);
    rdchk(ST, 8'h00);
    dualInputMode <= 1'b1;
    @(posedge clock);
    rdchk(ST, 8'h40);
    rdchk(ST, 8'h40);
    inputErrB <= 5'h00;
    laneErrA <= 2'h2;
    @(posedge clock);
    rdchk(ST, 8'h20);
    laneErrA <= 2'h0;
    laneErrB <= 2'h1;
    @(posedge clock);
    rdchk(ST, 8'h20);
    laneErrB <= 2'h0;
    pulse(1, 2'h1);
    rdchk(ST, 8'h02);
    pulse(0, 2'h1);
    rdchk(ST, 8'h10);
    errClear;
    rdchk(ST, 8'h00);
    pulse(2, 2'h1);
    rdchk(ST, 8'h08);
    pulse(3, 2'h1);
    rdchk(ST, 8'h00);
    pulse(2, 2'h1);
    errClear;
    rdchk(ST, 8'h00);
    cableDetect <= 2'h2;
    pixelClockValid <= 2'h2;
    pulse(0, 2'h2);
    rdchk(ST, 8'h00);
    wr(SEL, 8'h01);
    rdchk(ST, 8'h15);
    errClear;
    rdchk(ST, 8'h05);
    {cableDetect, pixelClockValid} <= 4'hF;
    wr(SEL, 8'h00);
    rdchk(ST, 8'h05);
    linkUp <= 2'h3;
    remoteData0 <= 3'h2;
    wr(P12, 8'h09);
    look(1, 2'h3);
    wr(P12, 8'h01);
    look(1, 2'h2);
    wr(P12, 8'h0B);
    look(1, 2'h0);
    wr(P12, 8'h06);
    look(1, 2'h0);
    wr(P12, 8'h05);
    look(1, 2'h3);
    linkUp <= 2'h0;
    remoteData0 <= 3'h0;
    look(1, 2'h3);
    wr(P12, 8'h0F);
    look(1, 2'h3);
    linkUp <= 2'h3;
    look(1, 2'h2);
    wr(P12, 8'h90);
    look(2, 2'h3);
    look(1, 2'h0);
    wr(P0, 8'h09);
    look(0, 2'h3);
    wr(SEL, 8'h01);
    wr(P12, 8'h09);
    look(4, 2'h3);
    look(2, 2'h3);
    remoteData1 <= 3'h1;
    wr(P0, 8'h05);
    look(3, 2'h3);
    wr(SEL, 8'h00);
    {extOe, extLevel} <= 12'h082;
    look(6, 2'h2);
    wr(P12, 8'h03);
    look(6, 2'h1);
    wr(IST, 8'h7F);
    wr(lspc_pkg::IRQ_MASK_ADDR, 8'h10);
    pulse(0, 2'h1);
    look(7, 2'h1);
    wr(IST, 8'h10);
    look(7, 2'h0);
    pulse(1, 2'h1);
    look(7, 2'h0);
    rdchk(IST, 8'h02);
    testDone;
  end
  initial begin
    #40000;
    failCount++;
    testDone;
  end
endmodule : testbench
`default_nettype wire
